// *** inc/protocol_regs_defs.vh ***
`ifndef PROTOCOL_REGS_DEFS_VH
`define PROTOCOL_REGS_DEFS_VH

// Configuration-space byte offsets.
`define CAPABILITY_OFFSET   12'h00A
`define CONTROL_OFFSET      12'h00C
`define LOCK_OFFSET         12'h014

// Capability field positions.
`define CAP_CACHE_BIT       0
`define CAP_IO_BIT          1
`define CAP_MEM_BIT         2
`define CAP_HWINIT_BIT      3
`define CAP_RANGE_LO        4
`define CAP_RANGE_HI        5
`define CAP_ISOLATE_BIT     14

// Control field positions.
`define CTL_CACHE_BIT       0
`define CTL_IO_BIT          1
`define CTL_MEM_BIT         2
`define CTL_COVER_LO        3
`define CTL_COVER_HI        7
`define CTL_GRAN_LO         8
`define CTL_GRAN_HI         10
`define CTL_CLEAN_BIT       11
`define CTL_ISOLATE_BIT     14

// Writable control bits: 0, 2, 7:3, 10:8, 11, 14.
`define CTL_LOCKABLE_MASK   16'h4FFD
`define CTL_RESET           16'h0000
`define LOCK_BIT            0
`define LOCK_RESET          1'b0
`define RDATA_IDLE          16'h0000

// Range-count codes.
`define RANGE_NONE          2'h0
`define RANGE_TWO           2'h2
`define RANGE_RESERVED      2'h3

`endif

// *** rtl/capability_word.v ***
`timescale 1ns/1ps
`include "protocol_regs_defs.vh"

// Builds the constant capability word from strap parameters.
module capability_word #(
  parameter       CACHE_CAPABLE   = 1,
  parameter       MEM_CAPABLE     = 1,
  parameter       HW_INIT         = 1,
  parameter [1:0] RANGE_COUNT     = 2'h1,
  parameter       ISOLATE_CAPABLE = 1
) (
  output wire [15:0] cap_word
);
  wire       mem_cap;
  wire [1:0] range_fix;

  assign mem_cap = (MEM_CAPABLE != 0);
  // Count is forced to zero without memory, and to at least one with it; reserved code maps to two.
  assign range_fix = !mem_cap ? `RANGE_NONE :
                     (RANGE_COUNT == `RANGE_NONE) ? 2'h1 :
                     (RANGE_COUNT == `RANGE_RESERVED) ? `RANGE_TWO :
                     RANGE_COUNT;

  assign cap_word[`CAP_CACHE_BIT]                 = (CACHE_CAPABLE != 0);
  assign cap_word[`CAP_IO_BIT]                    = 1'b1;
  assign cap_word[`CAP_MEM_BIT]                   = mem_cap;
  assign cap_word[`CAP_HWINIT_BIT]                = mem_cap & (HW_INIT != 0);
  assign cap_word[`CAP_RANGE_HI:`CAP_RANGE_LO]    = range_fix;
  assign cap_word[13:6]                           = 8'h00;
  assign cap_word[`CAP_ISOLATE_BIT]               = (ISOLATE_CAPABLE != 0);
  assign cap_word[15]                             = 1'b0;
endmodule

// *** rtl/protocol_capability_control_regs.v ***
`timescale 1ns/1ps
`include "protocol_regs_defs.vh"

module protocol_capability_control_regs #(
  parameter       CACHE_CAPABLE   = 1,
  parameter       MEM_CAPABLE     = 1,
  parameter       HW_INIT         = 1,
  parameter [1:0] RANGE_COUNT     = 2'h1,
  parameter       ISOLATE_CAPABLE = 1
) (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        cfg_read,
  input  wire        cfg_write,
  input  wire [11:0] cfg_addr,
  input  wire [1:0]  cfg_byte_en,
  input  wire [15:0] cfg_wdata,
  output reg  [15:0] cfg_rdata,
  output reg         cfg_ack,
  output reg         cache_enable,
  output reg         io_enable,
  output reg         mem_enable,
  output reg  [4:0]  host_filter_coverage,
  output reg  [2:0]  host_filter_granularity,
  output reg         clean_eviction_not_needed,
  output reg         isolation_enable,
  output reg         config_locked
);
  // Read source select codes.
  localparam [1:0] SEL_NONE = 2'b00;
  localparam [1:0] SEL_CAP  = 2'b01;
  localparam [1:0] SEL_CTL  = 2'b10;
  localparam [1:0] SEL_LOCK = 2'b11;

  wire [15:0] cap_word;
  wire [15:0] lane_mask;
  wire [15:0] write_mask;
  wire        hit_cap;
  wire        hit_ctl;
  wire        hit_lock;
  wire        ctl_write_strobe;
  wire        lock_write_strobe;
  wire        lock_set_request;
  wire [15:0] ctl_bit_write;
  wire [15:0] ctl_next;
  reg  [15:0] ctl_reg;
  reg         lock_reg;
  reg         lock_next;
  reg  [1:0]  read_sel;
  reg  [15:0] rdata_next;
  reg  [15:0] cfg_rdata_next;
  reg         cfg_ack_next;
  reg         cache_enable_next;
  reg         io_enable_next;
  reg         mem_enable_next;
  reg  [4:0]  host_filter_coverage_next;
  reg  [2:0]  host_filter_granularity_next;
  reg         clean_eviction_next;
  reg         isolation_enable_next;
  reg         config_locked_next;

  capability_word #(
    .CACHE_CAPABLE   (CACHE_CAPABLE),
    .MEM_CAPABLE     (MEM_CAPABLE),
    .HW_INIT         (HW_INIT),
    .RANGE_COUNT     (RANGE_COUNT),
    .ISOLATE_CAPABLE (ISOLATE_CAPABLE)
  ) u_cap (
    .cap_word (cap_word)
  );

  assign hit_cap  = (cfg_addr == `CAPABILITY_OFFSET);
  assign hit_ctl  = (cfg_addr == `CONTROL_OFFSET);
  assign hit_lock = (cfg_addr == `LOCK_OFFSET);
  assign lane_mask  = {{8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}};
  // Only lockable bits are ever writable; reserved and read-only bits stay put.
  assign write_mask = lane_mask & `CTL_LOCKABLE_MASK;

  // A control write lands only while the lock is clear; the lock never blocks its own write.
  assign ctl_write_strobe  = cfg_write & hit_ctl & ~lock_reg;
  assign lock_write_strobe = cfg_write & hit_lock & cfg_byte_en[0];
  assign lock_set_request  = lock_write_strobe & cfg_wdata[`LOCK_BIT];

  // Each control bit is written on its own lane and only if it belongs to a lockable field.
  genvar idx;
  generate
    for (idx = 0; idx < 16; idx = idx + 1) begin : ctl_bit
      assign ctl_bit_write[idx] = ctl_write_strobe & write_mask[idx];
      assign ctl_next[idx]      = ctl_bit_write[idx] ? cfg_wdata[idx] : ctl_reg[idx];
    end
  endgenerate

  always @* begin
    lock_next = lock_reg;
    // Lock can only go from clear to set; no write clears it.
    if (lock_set_request) begin
      lock_next = 1'b1;
    end
  end

  // Exact offset match picks the word; any other offset reads back as zero.
  always @* begin
    read_sel = SEL_NONE;
    if (hit_cap) begin
      read_sel = SEL_CAP;
    end else if (hit_ctl) begin
      read_sel = SEL_CTL;
    end else if (hit_lock) begin
      read_sel = SEL_LOCK;
    end
  end

  always @* begin
    rdata_next = `RDATA_IDLE;
    case (read_sel)
      SEL_CAP: begin
        rdata_next = cap_word;
      end
      SEL_CTL: begin
        rdata_next              = ctl_reg & `CTL_LOCKABLE_MASK;
        rdata_next[`CTL_IO_BIT] = 1'b1;
      end
      SEL_LOCK: begin
        rdata_next[`LOCK_BIT] = lock_reg;
      end
      default: begin
        rdata_next = `RDATA_IDLE;
      end
    endcase
  end

  // Every request is answered, mapped offset or not.
  always @* begin
    cfg_ack_next   = cfg_read | cfg_write;
    cfg_rdata_next = cfg_read ? rdata_next : `RDATA_IDLE;
  end

  // Field decode of the register image; the enable outputs register it one cycle later.
  always @* begin
    cache_enable_next            = ctl_reg[`CTL_CACHE_BIT];
    io_enable_next               = 1'b1;
    mem_enable_next              = ctl_reg[`CTL_MEM_BIT];
    host_filter_coverage_next    = ctl_reg[`CTL_COVER_HI:`CTL_COVER_LO];
    host_filter_granularity_next = ctl_reg[`CTL_GRAN_HI:`CTL_GRAN_LO];
    clean_eviction_next          = ctl_reg[`CTL_CLEAN_BIT];
    isolation_enable_next        = ctl_reg[`CTL_ISOLATE_BIT];
    config_locked_next           = lock_reg;
  end

  // Lockable fields start cleared, so every sub-protocol enable except io_enable is off until software sets it.
  always @(posedge sys_clk) begin
    if (reset) begin
      ctl_reg <= `CTL_RESET;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // The lock survives everything but reset.
  always @(posedge sys_clk) begin
    if (reset) begin
      lock_reg <= `LOCK_RESET;
    end else begin
      lock_reg <= lock_next;
    end
  end

  // The answer is a one-cycle pulse; read data is zero whenever no read is answered.
  always @(posedge sys_clk) begin
    if (reset) begin
      cfg_rdata <= `RDATA_IDLE;
      cfg_ack   <= 1'b0;
    end else begin
      cfg_rdata <= cfg_rdata_next;
      cfg_ack   <= cfg_ack_next;
    end
  end

  // Decoded enables follow the register one cycle later.
  always @(posedge sys_clk) begin
    if (reset) begin
      cache_enable              <= 1'b0;
      io_enable                 <= 1'b0;
      mem_enable                <= 1'b0;
      host_filter_coverage      <= 5'h00;
      host_filter_granularity   <= 3'h0;
      clean_eviction_not_needed <= 1'b0;
      isolation_enable          <= 1'b0;
      config_locked             <= 1'b0;
    end else begin
      cache_enable              <= cache_enable_next;
      io_enable                 <= io_enable_next;
      mem_enable                <= mem_enable_next;
      host_filter_coverage      <= host_filter_coverage_next;
      host_filter_granularity   <= host_filter_granularity_next;
      clean_eviction_not_needed <= clean_eviction_next;
      isolation_enable          <= isolation_enable_next;
      config_locked             <= config_locked_next;
    end
  end
endmodule

// *** test/protocol_regs_checker.sv ***
`timescale 1ns/1ps
module protocol_regs_checker (
  input wire        sys_clk,
  input wire        reset,
  input wire        cfg_read,
  input wire        cfg_write,
  input wire [11:0] cfg_addr,
  input wire [15:0] cfg_rdata,
  input wire        cfg_ack,
  input wire        cache_enable,
  input wire        io_enable,
  input wire        config_locked
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  ack_after_a: assert property ((cfg_read | cfg_write) |=> cfg_ack) else $error("no ack");
  ack_idle_a: assert property (!(cfg_read | cfg_write) |=> !cfg_ack) else $error("stray ack");
  cap_word_a: assert property (cfg_read && cfg_addr == 12'h00A |=> cfg_rdata == 16'h401F)
    else $error("capability word");
  ctl_fixed_a: assert property (cfg_read && cfg_addr == 12'h00C |=> (cfg_rdata & 16'hB002) == 16'h0002)
    else $error("control fixed bits");
  unmapped_zero_a: assert property (cfg_read && cfg_addr == 12'h010 |=> cfg_rdata == 16'h0000)
    else $error("unmapped read");
  lock_sticky_a: assert property (config_locked |=> config_locked) else $error("lock cleared");
  locked_freeze_a: assert property (config_locked && cfg_write && cfg_addr == 12'h00C |=> ##1 $stable(cache_enable))
    else $error("locked write landed");
  io_on_a: assert property (!$past(reset) && !$past(reset, 2) |-> io_enable) else $error("io off");
endmodule
bind protocol_capability_control_regs protocol_regs_checker chk_u (.*);

// *** test/cfg_host.sv ***
`timescale 1ns/1ps
module cfg_host (
  input  wire         sys_clk,
  input  wire         cfg_ack,
  input  wire  [15:0] cfg_rdata,
  output logic        cfg_read,
  output logic        cfg_write,
  output logic [11:0] cfg_addr,
  output logic [1:0]  cfg_byte_en,
  output logic [15:0] cfg_wdata
);
  initial {cfg_read, cfg_write, cfg_addr, cfg_byte_en, cfg_wdata} = '0;
  task xfer(input w, input [11:0] a, input [1:0] be, input [15:0] d, output [15:0] q, output bit to);
    int n;
    n = 0;
    @(posedge sys_clk) #1;
    {cfg_write, cfg_read, cfg_addr, cfg_byte_en, cfg_wdata} = {w, !w, a, be, d};
    @(posedge sys_clk) #1;
    // Strobes drop; address and write data show the inverse so a stale value never reads as valid.
    {cfg_write, cfg_read, cfg_addr, cfg_wdata} = {2'b00, ~a, ~d};
    while (cfg_ack !== 1'b1 && n < 4) begin
      @(posedge sys_clk) #1;
      n++;
    end
    q = cfg_rdata;
    to = (n == 4);
  endtask
endmodule

// *** test/test_protocol_capability_control_regs.sv ***
`timescale 1ns/1ps
module test_protocol_capability_control_regs;
  logic sys_clk = 0, reset = 1;
  wire cfg_read, cfg_write, cfg_ack, cache_enable, io_enable, mem_enable;
  wire clean_eviction_not_needed, isolation_enable, config_locked;
  wire [11:0] cfg_addr;
  wire [1:0] cfg_byte_en;
  wire [15:0] cfg_wdata, cfg_rdata;
  wire [4:0] host_filter_coverage;
  wire [2:0] host_filter_granularity;
  wire [15:0] ov = {1'b0, isolation_enable, 2'b00, clean_eviction_not_needed, host_filter_granularity,
                    host_filter_coverage, mem_enable, io_enable, cache_enable};
  int fail_count = 0, n_tests = 0;
  logic [15:0] lf = 16'h003A, q, d, ctl = 16'h0002;
  logic [1:0] be;
  bit to;
  always #2.5 sys_clk = ~sys_clk;
  protocol_capability_control_regs dut_u (.*);
  cfg_host host_u (.*);
  function automatic logic [15:0] nxt(input [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [15:0] upd(input [15:0] o, v, input [1:0] e);
    logic [15:0] m;
    m = 16'h4FFD & {{8{e[1]}}, {8{e[0]}}};
    return (o & ~m) | (v & m);
  endfunction
  task chk(input [15:0] g, e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task end_of_test;
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task acc(input w, input [11:0] a, input [1:0] e, input [15:0] v);
    host_u.xfer(w, a, e, v, q, to);
    if (to) begin
      fail_count++;
      end_of_test;
    end
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 reset = 0;
    acc(0, 12'h00C, 2'h3, 16'h0000);
    chk(q, ctl);
    for (int i = 0; i < 24; i++) begin
      lf = nxt(lf);
      d = {lf[15:11], i[2:0], lf[7:0]};
      be = i < 8 ? 2'h3 : lf[1:0];
      acc(1, i < 16 ? 12'h00C : 12'h00A, be, d);
      if (i < 16) ctl = upd(ctl, d, be);
      acc(0, 12'h00C, 2'h3, lf);
      chk(q, ctl);
      chk(ov, ctl);
      acc(0, 12'h00A, 2'h3, lf);
      chk(q, 16'h401F);
    end
    $display("register walk done");
    acc(0, 12'h010, 2'h3, 16'h0000);
    chk(q, 16'h0000);
    acc(1, 12'h014, 2'h2, 16'hFFFF);
    chk({15'h0, config_locked}, 16'h0000);
    acc(1, 12'h014, 2'h1, 16'h0001);
    acc(1, 12'h014, 2'h3, 16'h0000);
    chk({15'h0, config_locked}, 16'h0001);
    acc(1, 12'h00C, 2'h3, ~ctl);
    acc(0, 12'h00C, 2'h3, 16'h0000);
    chk(q, ctl);
    chk(ov, ctl);
    $display("lock test done");
    end_of_test;
  end
endmodule
